// ### dnc_consts.svh
`ifndef DNC_CONSTS_SVH
`define DNC_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DNC_OFS_TW_B0        8'h30
`define DNC_OFS_TW_B1        8'h31
`define DNC_OFS_TW_B2        8'h32
`define DNC_OFS_TW_B3        8'h33
`define DNC_OFS_PHASE_LO     8'h34
`define DNC_OFS_PHASE_HI     8'h35
`define DNC_OFS_UPDATE_CTL   8'h36
`define DNC_OFS_IQP_LO       8'h38
`define DNC_OFS_IQP_HI       8'h39
`define DNC_OFS_QQP_LO       8'h3a
`define DNC_OFS_QQP_HI       8'h3b
`define DNC_OFS_IOFS_LO      8'h3c
`define DNC_OFS_IOFS_HI      8'h3d
`define DNC_OFS_QOFS_LO      8'h3e
`define DNC_OFS_QOFS_HI      8'h3f
`define DNC_OFS_ITRIM_LO     8'h40
`define DNC_OFS_ICONV_CTL    8'h41
`define DNC_OFS_IAUX_LO      8'h42

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DNC_BIT_UPD_REQ      0
`define DNC_BIT_UPD_ACK      1
`define DNC_BIT_MRK_REQ      4
`define DNC_BIT_MRK_ACK      5
`define DNC_BIT_ICONV_SLEEP  7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DNC_RST_BYTE         8'h00
`define DNC_RST_ITRIM_LO     8'hf9
`define DNC_RST_ITRIM_HI     2'h1

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DNC_CLK_PERIOD_NS    4
`define DNC_MARKER_EXT_NS    16
`define DNC_MARKER_EXT_CYC   ((`DNC_MARKER_EXT_NS + `DNC_CLK_PERIOD_NS - 1) \
                              / `DNC_CLK_PERIOD_NS)

`endif

// ### dnc_pkg.sv
package dnc_pkg;

    typedef enum logic [0:0]
    {
        DNC_MK_IDLE  = 1'b0,
        DNC_MK_ARMED = 1'b1
    } dnc_mk_state_t;

    typedef logic [7:0]  dnc_byte_t;
    typedef logic [31:0] dnc_word_t;

endpackage

// ### dnc_rise_detect.sv
`timescale 1ns/1ns
module dnc_rise_detect
    import dnc_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic level_in,
    output logic      rise_pulse
);

    logic prev_r;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            prev_r <= 1'b0;
        else
            prev_r <= level_in;
    end

    // Only a 0 to 1 step counts; holding 1 does nothing
    assign rise_pulse = level_in & ~prev_r;

endmodule

// ### dnc_sample_offset.sv
`timescale 1ns/1ns
module dnc_sample_offset
    import dnc_pkg::*;
#(
    parameter int W = 16
)
(
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] sample_in,
    input  wire logic [W-1:0] offset_in,
    output logic      [W-1:0] sample_out
);

    logic [W-1:0] sum_nxt;

    // Wraps modulo 2^W; no saturation
    assign sum_nxt = W'(sample_in + offset_in);

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            sample_out <= '0;
        else
            sample_out <= sum_nxt;
    end

endmodule

// ### dnc_regs.sv
`timescale 1ns/1ns
`include "dnc_consts.svh"
module dnc_regs
    import dnc_pkg::*;
#(
    parameter int MARKER_EXT_CYCLES = `DNC_MARKER_EXT_CYC,
    parameter int SAMPLE_W          = 16
)
(
    input  wire logic                clk_sys,
    input  wire logic                sys_rst,
    input  wire logic                cfg_wr_en,
    input  wire logic                cfg_rd_en,
    input  wire logic [7:0]          cfg_addr,
    input  wire logic [7:0]          cfg_wr_data,
    output logic      [7:0]          cfg_rd_data,
    output logic                     cfg_rd_valid,
    input  wire logic                marker_pin,
    input  wire logic [SAMPLE_W-1:0] i_sample_in,
    input  wire logic [SAMPLE_W-1:0] q_sample_in,
    output logic      [SAMPLE_W-1:0] i_sample_out,
    output logic      [SAMPLE_W-1:0] q_sample_out,
    output logic      [31:0]         frequency_tuning_word,
    output logic      [31:0]         carrier_phase,
    output logic                     carrier_reset_pulse,
    output logic      [9:0]          i_quad_phase,
    output logic      [9:0]          q_quad_phase,
    output logic      [9:0]          i_fullscale_trim,
    output logic                     i_converter_sleep,
    output logic      [9:0]          i_aux_current
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    dnc_byte_t      tw_byte_r [4];
    logic [15:0]    phase_ofs_r;
    logic           upd_req_r;
    logic           upd_ack_r;
    logic           mrk_req_r;
    logic           mrk_ack_r;
    logic [9:0]     iqp_r;
    logic [9:0]     qqp_r;
    logic [15:0]    iofs_r;
    logic [15:0]    qofs_r;
    logic [9:0]     itrim_r;
    logic           isleep_r;
    logic [7:0]     iaux_lo_r;
    dnc_word_t      tw_active_r;
    dnc_word_t      phase_acc_r;
    dnc_mk_state_t  mk_state_r;
    dnc_mk_state_t  mk_state_nxt;
    logic           mk_sync1_r;
    logic           mk_sync2_r;
    logic [7:0]     mk_cnt_r;
    logic           carrier_rst_r;
    logic [7:0]     rd_data_nxt;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire wr_tw0   = cfg_wr_en && (cfg_addr == `DNC_OFS_TW_B0);
    wire wr_tw1   = cfg_wr_en && (cfg_addr == `DNC_OFS_TW_B1);
    wire wr_tw2   = cfg_wr_en && (cfg_addr == `DNC_OFS_TW_B2);
    wire wr_tw3   = cfg_wr_en && (cfg_addr == `DNC_OFS_TW_B3);
    wire wr_ph_lo = cfg_wr_en && (cfg_addr == `DNC_OFS_PHASE_LO);
    wire wr_ph_hi = cfg_wr_en && (cfg_addr == `DNC_OFS_PHASE_HI);
    wire wr_upd   = cfg_wr_en && (cfg_addr == `DNC_OFS_UPDATE_CTL);
    wire wr_iqplo = cfg_wr_en && (cfg_addr == `DNC_OFS_IQP_LO);
    wire wr_iqphi = cfg_wr_en && (cfg_addr == `DNC_OFS_IQP_HI);
    wire wr_qqplo = cfg_wr_en && (cfg_addr == `DNC_OFS_QQP_LO);
    wire wr_qqphi = cfg_wr_en && (cfg_addr == `DNC_OFS_QQP_HI);
    wire wr_iolo  = cfg_wr_en && (cfg_addr == `DNC_OFS_IOFS_LO);
    wire wr_iohi  = cfg_wr_en && (cfg_addr == `DNC_OFS_IOFS_HI);
    wire wr_qolo  = cfg_wr_en && (cfg_addr == `DNC_OFS_QOFS_LO);
    wire wr_qohi  = cfg_wr_en && (cfg_addr == `DNC_OFS_QOFS_HI);
    wire wr_trim  = cfg_wr_en && (cfg_addr == `DNC_OFS_ITRIM_LO);
    wire wr_ictl  = cfg_wr_en && (cfg_addr == `DNC_OFS_ICONV_CTL);
    wire wr_iaux  = cfg_wr_en && (cfg_addr == `DNC_OFS_IAUX_LO);

    wire upd_req_wbit = cfg_wr_data[`DNC_BIT_UPD_REQ];
    wire mrk_req_wbit = cfg_wr_data[`DNC_BIT_MRK_REQ];

    // ------------------------------------------------------------
    // Configuration writes
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            for (int k = 0; k < 4; k++)
                tw_byte_r[k] <= `DNC_RST_BYTE;
        end
        else
        begin
            // Staged only; the oscillator keeps tw_active_r
            if (wr_tw0) tw_byte_r[0] <= cfg_wr_data;
            if (wr_tw1) tw_byte_r[1] <= cfg_wr_data;
            if (wr_tw2) tw_byte_r[2] <= cfg_wr_data;
            if (wr_tw3) tw_byte_r[3] <= cfg_wr_data;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            phase_ofs_r <= {`DNC_RST_BYTE, `DNC_RST_BYTE};
            iqp_r       <= 10'h000;
            qqp_r       <= 10'h000;
        end
        else
        begin
            if (wr_ph_lo) phase_ofs_r[7:0]  <= cfg_wr_data;
            if (wr_ph_hi) phase_ofs_r[15:8] <= cfg_wr_data;
            if (wr_iqplo) iqp_r[7:0] <= cfg_wr_data;
            if (wr_iqphi) iqp_r[9:8] <= cfg_wr_data[1:0];
            if (wr_qqplo) qqp_r[7:0] <= cfg_wr_data;
            if (wr_qqphi) qqp_r[9:8] <= cfg_wr_data[1:0];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            iofs_r <= {`DNC_RST_BYTE, `DNC_RST_BYTE};
            qofs_r <= {`DNC_RST_BYTE, `DNC_RST_BYTE};
        end
        else
        begin
            if (wr_iolo) iofs_r[7:0]  <= cfg_wr_data;
            if (wr_iohi) iofs_r[15:8] <= cfg_wr_data;
            if (wr_qolo) qofs_r[7:0]  <= cfg_wr_data;
            if (wr_qohi) qofs_r[15:8] <= cfg_wr_data;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            itrim_r   <= {`DNC_RST_ITRIM_HI, `DNC_RST_ITRIM_LO};
            isleep_r  <= 1'b0;
            iaux_lo_r <= `DNC_RST_BYTE;
        end
        else
        begin
            if (wr_trim) itrim_r[7:0] <= cfg_wr_data;
            if (wr_ictl)
            begin
                itrim_r[9:8] <= cfg_wr_data[1:0];
                isleep_r     <= cfg_wr_data[`DNC_BIT_ICONV_SLEEP];
            end
            if (wr_iaux) iaux_lo_r <= cfg_wr_data;
        end
    end

    // ------------------------------------------------------------
    // Update request and acknowledge
    // ------------------------------------------------------------
    logic upd_rise;
    logic mrk_rise;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            upd_req_r <= 1'b0;
            mrk_req_r <= 1'b0;
        end
        else if (wr_upd)
        begin
            upd_req_r <= upd_req_wbit;
            mrk_req_r <= mrk_req_wbit;
        end
    end

    dnc_rise_detect u_upd_rise
    (
        .clk_sys    (clk_sys),
        .sys_rst    (sys_rst),
        .level_in   (upd_req_r),
        .rise_pulse (upd_rise)
    );

    dnc_rise_detect u_mrk_rise
    (
        .clk_sys    (clk_sys),
        .sys_rst    (sys_rst),
        .level_in   (mrk_req_r),
        .rise_pulse (mrk_rise)
    );

    // Clearing the request bit clears its ack; a new set wins
    wire upd_ack_clr = wr_upd && !upd_req_wbit;
    wire mrk_ack_clr = wr_upd && !mrk_req_wbit;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            tw_active_r <= 32'h0000_0000;
        else if (upd_rise)
            tw_active_r <= {tw_byte_r[3], tw_byte_r[2],
                            tw_byte_r[1], tw_byte_r[0]};
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            upd_ack_r <= 1'b0;
        else if (upd_rise)
            upd_ack_r <= 1'b1;
        else if (upd_ack_clr)
            upd_ack_r <= 1'b0;
    end

    // ------------------------------------------------------------
    // Burst marker input
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            mk_sync1_r <= 1'b0;
            mk_sync2_r <= 1'b0;
        end
        else
        begin
            mk_sync1_r <= marker_pin;
            mk_sync2_r <= mk_sync1_r;
        end
    end

    // Counter saturates so one long pulse yields one event only
    wire mk_cnt_full = (mk_cnt_r == 8'(MARKER_EXT_CYCLES));
    wire mk_extended = mk_sync2_r &&
                       (mk_cnt_r == 8'(MARKER_EXT_CYCLES - 1));

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            mk_cnt_r <= 8'h00;
        else if (!mk_sync2_r)
            mk_cnt_r <= 8'h00;
        else if (!mk_cnt_full)
            mk_cnt_r <= 8'(mk_cnt_r + 8'h01);
    end

    // ------------------------------------------------------------
    // Marker reset sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        mk_state_nxt = mk_state_r;
        unique case (mk_state_r)
            DNC_MK_IDLE:
                if (mrk_rise)
                    mk_state_nxt = DNC_MK_ARMED;
            DNC_MK_ARMED:
                if (mk_extended)
                    mk_state_nxt = DNC_MK_IDLE;
        endcase
    end

    // Only the first qualifying pulse after arming acts
    wire carrier_rst_nxt = (mk_state_r == DNC_MK_ARMED) && mk_extended;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            mk_state_r    <= DNC_MK_IDLE;
            carrier_rst_r <= 1'b0;
        end
        else
        begin
            mk_state_r    <= mk_state_nxt;
            carrier_rst_r <= carrier_rst_nxt;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            mrk_ack_r <= 1'b0;
        else if (carrier_rst_r)
            mrk_ack_r <= 1'b1;
        else if (mrk_ack_clr)
            mrk_ack_r <= 1'b0;
    end

    // ------------------------------------------------------------
    // Carrier oscillator phase accumulator
    // ------------------------------------------------------------
    // Offset sits in the top half; wraps as a signed turn fraction
    wire [31:0] phase_load = {phase_ofs_r, 16'h0000};

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            phase_acc_r <= 32'h0000_0000;
        else if (carrier_rst_r)
            phase_acc_r <= phase_load;
        else
            phase_acc_r <= 32'(phase_acc_r + tw_active_r);
    end

    // ------------------------------------------------------------
    // Datapath offset correction
    // ------------------------------------------------------------
    dnc_sample_offset #(.W(SAMPLE_W)) u_i_offset
    (
        .clk_sys    (clk_sys),
        .sys_rst    (sys_rst),
        .sample_in  (i_sample_in),
        .offset_in  (SAMPLE_W'(iofs_r)),
        .sample_out (i_sample_out)
    );

    dnc_sample_offset #(.W(SAMPLE_W)) u_q_offset
    (
        .clk_sys    (clk_sys),
        .sys_rst    (sys_rst),
        .sample_in  (q_sample_in),
        .offset_in  (SAMPLE_W'(qofs_r)),
        .sample_out (q_sample_out)
    );

    // ------------------------------------------------------------
    // Readback
    // ------------------------------------------------------------
    wire [7:0] upd_ctl_rd = {2'b00,
                             mrk_ack_r, mrk_req_r,
                             2'b00,
                             upd_ack_r, upd_req_r};

    always_comb
    begin
        rd_data_nxt = 8'h00;
        case (cfg_addr)
            `DNC_OFS_TW_B0:      rd_data_nxt = tw_byte_r[0];
            `DNC_OFS_TW_B1:      rd_data_nxt = tw_byte_r[1];
            `DNC_OFS_TW_B2:      rd_data_nxt = tw_byte_r[2];
            `DNC_OFS_TW_B3:      rd_data_nxt = tw_byte_r[3];
            `DNC_OFS_PHASE_LO:   rd_data_nxt = phase_ofs_r[7:0];
            `DNC_OFS_PHASE_HI:   rd_data_nxt = phase_ofs_r[15:8];
            `DNC_OFS_UPDATE_CTL: rd_data_nxt = upd_ctl_rd;
            `DNC_OFS_IQP_LO:     rd_data_nxt = iqp_r[7:0];
            `DNC_OFS_IQP_HI:     rd_data_nxt = {6'h00, iqp_r[9:8]};
            `DNC_OFS_QQP_LO:     rd_data_nxt = qqp_r[7:0];
            `DNC_OFS_QQP_HI:     rd_data_nxt = {6'h00, qqp_r[9:8]};
            `DNC_OFS_IOFS_LO:    rd_data_nxt = iofs_r[7:0];
            `DNC_OFS_IOFS_HI:    rd_data_nxt = iofs_r[15:8];
            `DNC_OFS_QOFS_LO:    rd_data_nxt = qofs_r[7:0];
            `DNC_OFS_QOFS_HI:    rd_data_nxt = qofs_r[15:8];
            `DNC_OFS_ITRIM_LO:   rd_data_nxt = itrim_r[7:0];
            `DNC_OFS_ICONV_CTL:  rd_data_nxt = {isleep_r, 5'h00,
                                                itrim_r[9:8]};
            `DNC_OFS_IAUX_LO:    rd_data_nxt = iaux_lo_r;
            default:             rd_data_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            cfg_rd_data  <= 8'h00;
            cfg_rd_valid <= 1'b0;
        end
        else
        begin
            cfg_rd_valid <= cfg_rd_en;
            if (cfg_rd_en)
                cfg_rd_data <= rd_data_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign frequency_tuning_word = tw_active_r;
    assign carrier_phase         = phase_acc_r;
    assign carrier_reset_pulse   = carrier_rst_r;
    assign i_quad_phase          = iqp_r;
    assign q_quad_phase          = qqp_r;
    assign i_fullscale_trim      = itrim_r;
    assign i_converter_sleep     = isleep_r;
    // Upper code bits live in a register outside this slice
    assign i_aux_current         = {2'b00, iaux_lo_r};

endmodule

// ### dnc_regs_monitor.sv
`timescale 1ns/1ns
module dnc_regs_monitor
    import dnc_pkg::*;
#(
    parameter int MARKER_EXT_CYCLES = 4,
    parameter int SAMPLE_W          = 16
)
(
    input wire logic                clk_sys,
    input wire logic                sys_rst,
    input wire logic                cfg_wr_en,
    input wire logic                cfg_rd_en,
    input wire logic [7:0]          cfg_addr,
    input wire logic [7:0]          cfg_wr_data,
    input wire logic [7:0]          cfg_rd_data,
    input wire logic                cfg_rd_valid,
    input wire logic                marker_pin,
    input wire logic [SAMPLE_W-1:0] i_sample_in,
    input wire logic [SAMPLE_W-1:0] q_sample_in,
    input wire logic [SAMPLE_W-1:0] i_sample_out,
    input wire logic [SAMPLE_W-1:0] q_sample_out,
    input wire logic [31:0]         frequency_tuning_word,
    input wire logic [31:0]         carrier_phase,
    input wire logic                carrier_reset_pulse,
    input wire logic [9:0]          i_quad_phase,
    input wire logic [9:0]          q_quad_phase,
    input wire logic [9:0]          i_fullscale_trim,
    input wire logic                i_converter_sleep,
    input wire logic [9:0]          i_aux_current
);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Hides pipeline values still left over from reset
    logic [1:0] up_cnt_r;
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            up_cnt_r <= 2'h0;
        else if (up_cnt_r != 2'h3)
            up_cnt_r <= up_cnt_r + 2'h1;
    end
    wire settled   = (up_cnt_r == 2'h3);
    wire wr_update = cfg_wr_en && cfg_addr == 8'h36 && cfg_wr_data[0];
    wire wr_ioff   = cfg_wr_en && (cfg_addr == 8'h3c || cfg_addr == 8'h3d);

    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    rd_answer_a: assert property (cfg_rd_en |=> cfg_rd_valid)
        else $error("read strobe not answered");
    rd_quiet_a: assert property (settled && !cfg_rd_en |=> !cfg_rd_valid)
        else $error("read valid without strobe");
    unmapped_zero_a: assert property (cfg_rd_en && cfg_addr == 8'h37
        |=> cfg_rd_data == 8'h00) else $error("unmapped read not zero");
    word_hold_a: assert property (settled && $changed(frequency_tuning_word)
        |-> $past(wr_update) || $past(wr_update, 2))
        else $error("tuning word moved without update request");
    phase_accum_a: assert property (settled && !$past(carrier_reset_pulse)
        |-> carrier_phase == $past(carrier_phase)
            + $past(frequency_tuning_word))
        else $error("carrier phase did not advance by tuning word");
    reload_once_a: assert property (carrier_reset_pulse
        |=> carrier_phase[15:0] == 16'h0000 && !carrier_reset_pulse)
        else $error("bad oscillator reload");
    marker_cause_a: assert property ($rose(carrier_reset_pulse)
        |-> $past(marker_pin, 3))
        else $error("oscillator reset without marker");
    trim_reset_a: assert property ($fell(sys_rst)
        |-> i_fullscale_trim == 10'h1f9)
        else $error("trim reset value wrong");
    sleep_write_a: assert property (cfg_wr_en && cfg_addr == 8'h41
        |=> i_converter_sleep == $past(cfg_wr_data[7])
            && i_fullscale_trim[9:8] == $past(cfg_wr_data[1:0]))
        else $error("control write not applied");
    aux_write_a: assert property (cfg_wr_en && cfg_addr == 8'h42
        |=> i_aux_current == {2'b00, $past(cfg_wr_data)})
        else $error("aux current write not applied");
    quad_write_a: assert property (cfg_wr_en && cfg_addr == 8'h39
        |=> i_quad_phase[9:8] == $past(cfg_wr_data[1:0]))
        else $error("quad phase write not applied");
    q_quad_write_a: assert property (cfg_wr_en && cfg_addr == 8'h3b
        |=> q_quad_phase[9:8] == $past(cfg_wr_data[1:0]))
        else $error("q quad phase write not applied");
    offset_hold_a: assert property (settled && !$past(wr_ioff)
        && !$past(wr_ioff, 2) && !$past(wr_ioff, 3)
        |-> SAMPLE_W'(i_sample_out - $past(i_sample_in))
            == SAMPLE_W'($past(i_sample_out) - $past(i_sample_in, 2)))
        else $error("sample offset not constant");
endmodule

bind dnc_regs dnc_regs_monitor #(
    .MARKER_EXT_CYCLES(MARKER_EXT_CYCLES), .SAMPLE_W(SAMPLE_W)) u_mon (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .cfg_wr_en(cfg_wr_en),
    .cfg_rd_en(cfg_rd_en), .cfg_addr(cfg_addr), .cfg_wr_data(cfg_wr_data),
    .cfg_rd_data(cfg_rd_data), .cfg_rd_valid(cfg_rd_valid),
    .marker_pin(marker_pin), .i_sample_in(i_sample_in),
    .q_sample_in(q_sample_in), .i_sample_out(i_sample_out),
    .q_sample_out(q_sample_out),
    .frequency_tuning_word(frequency_tuning_word),
    .carrier_phase(carrier_phase), .carrier_reset_pulse(carrier_reset_pulse),
    .i_quad_phase(i_quad_phase), .q_quad_phase(q_quad_phase),
    .i_fullscale_trim(i_fullscale_trim),
    .i_converter_sleep(i_converter_sleep), .i_aux_current(i_aux_current));

// ### dnc_regs_test.sv
`timescale 1ns/1ns
module dnc_regs_test
    import dnc_pkg::*;
;
    localparam int EXT = 3;
    logic        clk_sys     = 1'b0;
    logic        sys_rst     = 1'b1;
    logic        cfg_wr_en   = 1'b0;
    logic        cfg_rd_en   = 1'b0;
    dnc_byte_t   cfg_addr    = 8'h00;
    dnc_byte_t   cfg_wr_data = 8'h00;
    logic        marker_pin  = 1'b0;
    logic [15:0] i_in        = 16'hffff;
    logic [15:0] q_in        = 16'h8000;
    dnc_byte_t   rd_data;
    logic        rd_valid, pulse, sleep;
    logic [15:0] i_out, q_out;
    dnc_word_t   act_word, phase;
    logic [9:0]  iqp, qqp, trim, aux;
    int          bad_count   = 0;
    int          check_count = 0;
    int          pulses      = 0;

    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (pulse === 1'b1) pulses++;

    dnc_regs #(.MARKER_EXT_CYCLES(EXT)) dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .cfg_wr_en(cfg_wr_en),
        .cfg_rd_en(cfg_rd_en), .cfg_addr(cfg_addr),
        .cfg_wr_data(cfg_wr_data), .cfg_rd_data(rd_data),
        .cfg_rd_valid(rd_valid), .marker_pin(marker_pin),
        .i_sample_in(i_in), .q_sample_in(q_in), .i_sample_out(i_out),
        .q_sample_out(q_out), .frequency_tuning_word(act_word),
        .carrier_phase(phase), .carrier_reset_pulse(pulse),
        .i_quad_phase(iqp), .q_quad_phase(qqp), .i_fullscale_trim(trim),
        .i_converter_sleep(sleep), .i_aux_current(aux));

    // ----------------------------------------------------------------
    // Access tasks
    // ----------------------------------------------------------------
    task automatic stop_test;
        if (bad_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input dnc_byte_t a, input dnc_byte_t d);
        @(posedge clk_sys);
        cfg_wr_en   <= 1'b1;
        cfg_addr    <= a;
        cfg_wr_data <= d;
        @(posedge clk_sys);
        cfg_wr_en <= 1'b0;
    endtask
    task automatic rd(input dnc_byte_t a, input dnc_byte_t exp);
        @(posedge clk_sys);
        cfg_rd_en <= 1'b1;
        cfg_addr  <= a;
        @(posedge clk_sys);
        cfg_rd_en <= 1'b0;
        #1;
        chk("read valid", 32'h1, {31'h0, rd_valid});
        chk($sformatf("reg %h", a), {24'h0, exp}, {24'h0, rd_data});
    endtask
    task automatic mark(input int len);
        @(posedge clk_sys);
        marker_pin <= 1'b1;
        repeat (len) @(posedge clk_sys);
        marker_pin <= 1'b0;
    endtask
    task automatic wait_pulse;
        int n;
        n = 0;
        while (pulse !== 1'b1)
        begin
            cycles(1);
            n++;
            if (n > 40)
            begin
                bad_count++;
                stop_test();
            end
        end
    endtask
    // Pattern unique per address so swapped bytes show up
    function automatic dnc_byte_t dv(input dnc_byte_t a);
        return a ^ 8'h5a;
    endfunction
    function automatic dnc_byte_t expv(input dnc_byte_t a);
        case (a)
            8'h37: return 8'h00;
            8'h39, 8'h3b: return dv(a) & 8'h03;
            8'h41: return dv(a) & 8'h83;
            default: return dv(a);
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        for (int a = 8'h30; a <= 8'h42; a++)
            rd(8'(a), a == 8'h40 ? 8'hf9 : 8'(a == 8'h41));
        chk("trim", 32'h1f9, {22'h0, trim});
        for (int a = 8'h30; a <= 8'h42; a++)
            if (a != 8'h36)
                wr(8'(a), dv(8'(a)));
        for (int a = 8'h30; a <= 8'h42; a++)
            if (a != 8'h36)
                rd(8'(a), expv(8'(a)));
        chk("staged word", 32'h0, act_word);
        chk("i quad", 32'h362, {22'h0, iqp});
        chk("q quad", 32'h160, {22'h0, qqp});
        chk("trim", 32'h31a, {22'h0, trim});
        chk("aux", 32'h018, {22'h0, aux});
        chk("i sample", 32'h6765, {16'h0, i_out});
        chk("q sample", 32'he564, {16'h0, q_out});
        wr(8'h36, 8'h01);
        cycles(3);
        chk("word", 32'h69686b6a, act_word);
        rd(8'h36, 8'h03);
        wr(8'h30, 8'h11);
        wr(8'h36, 8'h01);
        cycles(3);
        chk("word held", 32'h69686b6a, act_word);
        wr(8'h36, 8'h00);
        rd(8'h36, 8'h00);
        wr(8'h36, 8'h01);
        cycles(3);
        chk("word again", 32'h69686b11, act_word);
        mark(EXT + 4);
        cycles(8);
        chk("unarmed", 32'h0, pulses);
        wr(8'h35, 8'h80);
        wr(8'h36, 8'h10);
        mark(1);
        cycles(8);
        chk("short marker", 32'h0, pulses);
        fork
            mark(EXT + 4);
            begin
                wait_pulse();
                cycles(1);
                chk("phase", 32'h806e0000, phase);
            end
        join
        rd(8'h36, 8'h30);
        mark(EXT + 4);
        cycles(8);
        chk("one per arm", 32'h1, pulses);
        wr(8'h41, 8'h80);
        cycles(1);
        chk("sleep", 32'h1, {31'h0, sleep});
        chk("trim hi", 32'h01a, {22'h0, trim});
        rd(8'h41, 8'h80);
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        #1;
        chk("trim rst", 32'h1f9, {22'h0, trim});
        chk("word rst", 32'h0, act_word);
        stop_test();
    end
endmodule
